// ===== logic/tcc_cfg.svh
/*
 * Constants of the timer count-control block: register offsets, field
 * positions, reset values and source codes.
 * Assumes it is included by the design files and by the bench.
 */
// Summary of operation
// - clear-on-match-A set clears the count at match A, else it runs free.
// - source codes 000 to 100 count the clock divided by 1, 2, 4, 8, 32.
// - source code 101 counts each rising edge of the external event input.
// - code 110 counts the fast oscillator; code 111 is reserved and counts nothing.
// - undivided clock in subclock state counts the subclock instead.
// - each channel pin shows its initial-level bit until its first match.
// - in PWM mode initial-level bits of B, C, D set output polarity.
// - a write to an initial-level bit changes the pin at once.
// - trigger edge select: 00 off, 01 rising, 10 falling, 11 both edges.
// - trigger edge select only acts while dual-PWM mode select is 0.
// - stop-on-match-A with dual-PWM select 0 halts counting at match A.
// - low five bits of trigger control ignore writes and read as ones.
// - dual-PWM select 0 means dual-PWM mode, per-pin PWM bits ignored.
// - in dual-PWM mode with stop set, match A clears the counter-start bit.
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// register byte offsets
`define TCC_OFS_COUNT_CONTROL   8'h00
`define TCC_OFS_TRIGGER_CONTROL 8'h04
`define TCC_OFS_MODE            8'h08
`define TCC_OFS_TIMER_COUNT     8'h0c
`define TCC_OFS_COMPARE_A       8'h10
`define TCC_OFS_COMPARE_D       8'h1c

// count_control fields
`define TCC_CC_CLEAR_BIT        7
`define TCC_CC_SRC_HI           6
`define TCC_CC_SRC_LO           4
`define TCC_CC_INIT_HI          3
`define TCC_CC_INIT_LO          0
`define TCC_CC_RESET            8'h00

// trigger_control fields
`define TCC_TC_EDGE_HI          7
`define TCC_TC_EDGE_LO          6
`define TCC_TC_STOP_BIT         5
`define TCC_TC_RSVD             5'h1f

// mode register fields
`define TCC_MD_START_BIT        7
`define TCC_MD_RSVD_BIT         6
`define TCC_MD_DUAL_BIT         3
`define TCC_MD_PWM_HI           2
`define TCC_MD_PWM_LO           0

// clock source codes
`define TCC_SRC_DIV1            3'h0
`define TCC_SRC_DIV2            3'h1
`define TCC_SRC_DIV4            3'h2
`define TCC_SRC_DIV8            3'h3
`define TCC_SRC_DIV32           3'h4
`define TCC_SRC_EVENT           3'h5
`define TCC_SRC_FAST            3'h6

// trigger edge codes
`define TCC_EDGE_RISE_BIT       0
`define TCC_EDGE_FALL_BIT       1

// prescaler taps for the divided enables
`define TCC_TAP_DIV2            0
`define TCC_TAP_DIV4            1
`define TCC_TAP_DIV8            2
`define TCC_TAP_DIV32           4

// bus responses
`define TCC_RESP_OKAY           2'h0
`define TCC_RESP_SLVERR         2'h2

`endif

// ===== logic/tcc_pkg.sv
/*
 * Types of the timer count-control block: AXI4-Lite channel bundles.
 * Assumes a 32-bit data AXI4-Lite master on the other side.
 */
package tcc_pkg;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } tcc_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tcc_axi_rsp_type;

endpackage : tcc_pkg

// ===== logic/tcc_prescaler.sv
/*
 * Free-running prescaler giving one-cycle count enables at 1/2^(k+1).
 * Assumes a single clock; ce low freezes it with the rest of the block.
 */
`include "tcc_cfg.svh"

module tcc_prescaler #(
    parameter int TAPS = 5
) (
    // clock and control
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            ce,
    // enables
    output logic [TAPS-1:0]      tick
);
    logic [TAPS-1:0] cnt;
    logic [TAPS-1:0] next_cnt;
    logic [TAPS-1:0] next_tick;

    always_comb begin
        next_cnt = cnt + TAPS'(1);
    end

    // enables rather than derived clocks keep one clock tree
    generate
        for (genvar k = 0; k < TAPS; k++) begin : g_tap
            always_comb begin
                next_tick[k] = &next_cnt[k:0];
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt  <= '0;
            tick <= '0;
        end else if (ce) begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

    a_tick_single: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && tick[0] |=> !tick[0])
        else $error("divide-by-two enable held two cycles");

endmodule : tcc_prescaler

// ===== logic/tcc_top.sv
/*
 * Timer count-control block: count source, clear and stop at match A,
 * external trigger, four channel pin levels, AXI4-Lite register slave.
 * Assumes all inputs synchronous to aclk except the event and trigger
 * pins, which are synchronised here; one write and one read in flight.
 */
`include "tcc_cfg.svh"

module tcc_top #(
    parameter int CNT_W = 16
) (
    // clock, reset, enable
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 ce,
    // register bus
    input  tcc_pkg::tcc_axi_req_type  axi_req,
    output tcc_pkg::tcc_axi_rsp_type  axi_rsp,
    // count sources
    input  wire logic                 subclock_mode,
    input  wire logic                 subclock_tick,
    input  wire logic                 fast_oscillator_clock,
    input  wire logic                 external_event_input,
    input  wire logic                 external_trigger,
    // channel pins a to d
    output logic [3:0]                channel_pin
);
    // bus state
    logic                      aw_full, next_aw_full;
    logic [7:0]                aw_addr, next_aw_addr;
    logic                      w_full, next_w_full;
    logic [31:0]               w_data, next_w_data;
    logic [3:0]                w_strb, next_w_strb;
    tcc_pkg::tcc_axi_rsp_type  next_rsp;
    logic                      do_write;
    logic [7:0]                wr_addr;
    // register state
    logic [7:0]                count_control, next_count_control;
    logic [1:0]                edge_sel, next_edge_sel;
    logic                      stop_on_match_a, next_stop_on_match_a;
    logic                      counter_start, next_counter_start;
    logic                      dual_pwm_mode_select, next_dual_pwm_mode_select;
    logic [2:0]                pwm_sel, next_pwm_sel;
    logic [CNT_W-1:0]          timer_count, next_timer_count;
    logic [CNT_W-1:0]          compare [4];
    logic [CNT_W-1:0]          next_compare [4];
    logic [3:0]                toggled, next_toggled;
    logic [3:0]                next_pin;
    // decoded hits and count terms
    logic                      wr_cc, wr_tc, wr_md, wr_cnt;
    logic [4:0]                pre_tick;
    logic                      src_tick, count_tick, trig_hit, stop_hit;
    logic [3:0]                match, pwm_act;
    logic [2:0]                ev_sync, tr_sync;
    logic                      ev_rise, tr_rise, tr_fall;
    logic [2:0]                src;

    assign src = count_control[`TCC_CC_SRC_HI:`TCC_CC_SRC_LO];

    tcc_prescaler #(
        .TAPS (5)
    ) u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .tick    (pre_tick)
    );

    // pin synchronisers: stage 0 feeds only stage 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_sync <= '0;
            tr_sync <= '0;
        end else if (ce) begin
            ev_sync <= {ev_sync[1:0], external_event_input};
            tr_sync <= {tr_sync[1:0], external_trigger};
        end
    end
    assign ev_rise = ev_sync[1] & ~ev_sync[2];
    assign tr_rise = tr_sync[1] & ~tr_sync[2];
    assign tr_fall = ~tr_sync[1] & tr_sync[2];

    // bus channel handling
    always_comb begin
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full  = w_full;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_rsp     = axi_rsp;
        if (axi_req.awvalid && axi_rsp.awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = axi_req.awaddr[7:0];
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            next_w_full = 1'b1;
            next_w_data = axi_req.wdata;
            next_w_strb = axi_req.wstrb;
        end
        if (axi_rsp.bvalid && axi_req.bready) begin
            next_rsp.bvalid = 1'b0;
        end
        do_write = next_aw_full && next_w_full && !next_rsp.bvalid;
        wr_addr  = next_aw_addr;
        if (do_write) begin
            next_aw_full   = 1'b0;
            next_w_full    = 1'b0;
            next_rsp.bvalid = 1'b1;
            next_rsp.bresp = (wr_addr[1:0] == 2'h0 &&
                              wr_addr <= `TCC_OFS_COMPARE_D) ?
                             `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        end
        if (axi_rsp.rvalid && axi_req.rready) begin
            next_rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && axi_rsp.arready) begin
            next_rsp.rvalid = 1'b1;
            next_rsp.rresp  = `TCC_RESP_OKAY;
            next_rsp.rdata  = '0;
            case (axi_req.araddr[7:0])
                `TCC_OFS_COUNT_CONTROL:   next_rsp.rdata[7:0] = count_control;
                `TCC_OFS_TRIGGER_CONTROL: next_rsp.rdata[7:0] =
                    {edge_sel, stop_on_match_a, `TCC_TC_RSVD};
                `TCC_OFS_MODE:            next_rsp.rdata[7:0] =
                    {counter_start, 1'b1, 2'h0, dual_pwm_mode_select, pwm_sel};
                `TCC_OFS_TIMER_COUNT:     next_rsp.rdata[CNT_W-1:0] = timer_count;
                8'h10: next_rsp.rdata[CNT_W-1:0] = compare[0];
                8'h14: next_rsp.rdata[CNT_W-1:0] = compare[1];
                8'h18: next_rsp.rdata[CNT_W-1:0] = compare[2];
                `TCC_OFS_COMPARE_D:       next_rsp.rdata[CNT_W-1:0] = compare[3];
                default: next_rsp.rresp = `TCC_RESP_SLVERR;
            endcase
        end
        // ready only while the matching slot is free
        next_rsp.awready = !next_aw_full && !next_rsp.bvalid;
        next_rsp.wready  = !next_w_full && !next_rsp.bvalid;
        next_rsp.arready = !next_rsp.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
            w_full  <= 1'b0;
            w_data  <= '0;
            w_strb  <= '0;
            axi_rsp <= '0;
        end else if (ce) begin
            aw_full <= next_aw_full;
            aw_addr <= next_aw_addr;
            w_full  <= next_w_full;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            axi_rsp <= next_rsp;
        end
    end

    assign wr_cc  = do_write && wr_addr == `TCC_OFS_COUNT_CONTROL && next_w_strb[0];
    assign wr_tc  = do_write && wr_addr == `TCC_OFS_TRIGGER_CONTROL && next_w_strb[0];
    assign wr_md  = do_write && wr_addr == `TCC_OFS_MODE && next_w_strb[0];
    assign wr_cnt = do_write && wr_addr == `TCC_OFS_TIMER_COUNT;

    // count source selection
    always_comb begin
        case (src)
            `TCC_SRC_DIV1:  src_tick = subclock_mode ? subclock_tick : 1'b1;
            `TCC_SRC_DIV2:  src_tick = pre_tick[`TCC_TAP_DIV2];
            `TCC_SRC_DIV4:  src_tick = pre_tick[`TCC_TAP_DIV4];
            `TCC_SRC_DIV8:  src_tick = pre_tick[`TCC_TAP_DIV8];
            `TCC_SRC_DIV32: src_tick = pre_tick[`TCC_TAP_DIV32];
            `TCC_SRC_EVENT: src_tick = ev_rise;
            `TCC_SRC_FAST:  src_tick = fast_oscillator_clock;
            default:        src_tick = 1'b0;
        endcase
    end
    assign count_tick = counter_start && src_tick;
    assign trig_hit   = !dual_pwm_mode_select &&
        ((edge_sel[`TCC_EDGE_RISE_BIT] && tr_rise) ||
         (edge_sel[`TCC_EDGE_FALL_BIT] && tr_fall));
    assign stop_hit   = stop_on_match_a && !dual_pwm_mode_select && match[0];

    // counter and control registers
    always_comb begin
        next_count_control        = count_control;
        next_edge_sel             = edge_sel;
        next_stop_on_match_a      = stop_on_match_a;
        next_counter_start        = counter_start;
        next_dual_pwm_mode_select = dual_pwm_mode_select;
        next_pwm_sel              = pwm_sel;
        next_timer_count          = timer_count;
        next_compare              = compare;
        if (wr_cc) begin
            next_count_control = next_w_data[7:0];
        end
        if (wr_tc) begin
            next_edge_sel        = next_w_data[`TCC_TC_EDGE_HI:`TCC_TC_EDGE_LO];
            next_stop_on_match_a = next_w_data[`TCC_TC_STOP_BIT];
        end
        if (stop_hit) begin
            next_counter_start = 1'b0;
        end
        // software write of the start bit wins over the hardware clear
        if (wr_md) begin
            next_counter_start        = next_w_data[`TCC_MD_START_BIT];
            next_dual_pwm_mode_select = next_w_data[`TCC_MD_DUAL_BIT];
            next_pwm_sel = next_w_data[`TCC_MD_PWM_HI:`TCC_MD_PWM_LO];
        end
        if (count_tick) begin
            if (count_control[`TCC_CC_CLEAR_BIT] && match[0]) begin
                next_timer_count = '0;
            end else begin
                next_timer_count = timer_count + CNT_W'(1);
            end
        end
        if (trig_hit) begin
            next_timer_count = '0;
        end
        if (wr_cnt) begin
            next_timer_count = next_w_data[CNT_W-1:0];
        end
        for (int i = 0; i < 4; i++) begin
            if (do_write && wr_addr == `TCC_OFS_COMPARE_A + 8'(4 * i)) begin
                next_compare[i] = next_w_data[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_control        <= `TCC_CC_RESET;
            edge_sel             <= '0;
            stop_on_match_a      <= 1'b0;
            counter_start        <= 1'b0;
            dual_pwm_mode_select <= 1'b1;
            pwm_sel              <= '0;
            timer_count          <= '0;
            compare              <= '{default: '0};
        end else if (ce) begin
            count_control        <= next_count_control;
            edge_sel             <= next_edge_sel;
            stop_on_match_a      <= next_stop_on_match_a;
            counter_start        <= next_counter_start;
            dual_pwm_mode_select <= next_dual_pwm_mode_select;
            pwm_sel              <= next_pwm_sel;
            timer_count          <= next_timer_count;
            compare              <= next_compare;
        end
    end

    // channel outputs: pin is initial level xor the match history
    generate
        for (genvar c = 0; c < 4; c++) begin : g_chan
            always_comb begin
                match[c] = count_tick && timer_count == compare[c];
                if (c == 0) begin
                    pwm_act[c] = 1'b0;
                end else begin
                    pwm_act[c] = !dual_pwm_mode_select || pwm_sel[c-1];
                end
                next_toggled[c] = toggled[c];
                if (pwm_act[c]) begin
                    if (match[c]) begin
                        next_toggled[c] = 1'b1;
                    end else if (match[0]) begin
                        next_toggled[c] = 1'b0;
                    end
                end else if (match[c]) begin
                    next_toggled[c] = !toggled[c];
                end
                next_pin[c] = next_count_control[`TCC_CC_INIT_LO + c] ^
                              next_toggled[c];
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            toggled     <= '0;
            channel_pin <= '0;
        end else if (ce) begin
            toggled     <= next_toggled;
            channel_pin <= next_pin;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_clear_on_a: assert property (ce && match[0] && !wr_cnt && !trig_hit &&
        count_control[`TCC_CC_CLEAR_BIT] |=> timer_count == '0)
        else $error("count not cleared at match A");
    a_free_run: assert property (ce && count_tick && !wr_cnt && !trig_hit &&
        !count_control[`TCC_CC_CLEAR_BIT]
        |=> timer_count == $past(timer_count) + CNT_W'(1))
        else $error("count did not advance");
    a_div2_rate: assert property (ce && count_tick && !wr_cc &&
        src == `TCC_SRC_DIV2 |=> !count_tick)
        else $error("divide-by-two source counted twice in a row");
    a_event_edge: assert property (src == `TCC_SRC_EVENT && counter_start
        |-> count_tick == ev_rise)
        else $error("event count not tied to rising edge");
    a_reserved_src: assert property (src == 3'h7 |-> !count_tick)
        else $error("reserved source counted");
    a_subclock: assert property (src == `TCC_SRC_DIV1 && subclock_mode &&
        !subclock_tick |-> !count_tick)
        else $error("main clock counted in subclock state");
    a_pin_level: assert property (channel_pin ==
        (count_control[`TCC_CC_INIT_HI:`TCC_CC_INIT_LO] ^ toggled))
        else $error("pin differs from initial level and history");
    a_init_write: assert property (ce && wr_cc && !(|match) |=>
        channel_pin == ($past(next_w_data[3:0]) ^ $past(toggled)))
        else $error("initial level write not reflected");
    a_pwm_polar: assert property (ce && pwm_act[1] && match[0] && !match[1]
        && !wr_cc |=> channel_pin[1] == count_control[1])
        else $error("pwm pin b not at polarity level after match A");
    a_trig_clear: assert property (ce && trig_hit && !wr_cnt
        |=> timer_count == '0)
        else $error("trigger did not clear the count");
    a_trig_off: assert property (dual_pwm_mode_select |-> !trig_hit)
        else $error("trigger acted outside dual-PWM mode");
    a_stop_match: assert property (ce && stop_hit && !wr_md
        |=> !counter_start ##1 $stable(timer_count) || !ce)
        else $error("count not halted at match A");
    a_dual_pwm: assert property (!dual_pwm_mode_select |-> &pwm_act[3:1])
        else $error("dual-PWM mode did not force pwm channels");
    a_rsvd_read: assert property (ce && axi_req.arvalid && axi_rsp.arready
        && axi_req.araddr[7:0] == `TCC_OFS_TRIGGER_CONTROL
        |=> axi_rsp.rdata[4:0] == `TCC_TC_RSVD)
        else $error("reserved trigger bits not read as ones");

    c_event_count: cover property (src == `TCC_SRC_EVENT && count_tick);
    c_stop_a:      cover property (stop_hit);
    c_trig:        cover property (trig_hit);
    c_pin_toggle:  cover property (ce && match[2] ##1 channel_pin[2]);

endmodule : tcc_top

// ===== tb/timer_count_control_tb.sv
/*
 * Self-checking bench of the timer count-control block: AXI4-Lite tasks
 * and one task per scenario.
 * Assumes tcc_top with default CNT_W and tcc_cfg.svh on the include path.
 */
`include "tcc_cfg.svh"

module timer_count_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     aclk;
    logic                     aresetn;
    logic                     ce;
    tcc_pkg::tcc_axi_req_type axi_req;
    tcc_pkg::tcc_axi_rsp_type axi_rsp;
    logic                     subclock_mode;
    logic                     external_event_input;
    logic                     external_trigger;
    logic [3:0]               channel_pin;
    logic [7:0]               tick_cnt;
    logic [31:0]              cnt;
    logic [1:0]               rsp;
    int                       mismatches;
    int                       cmp_count;
    int                       cycles;

    // fast oscillator pulses every 4 cycles, subclock every 8
    tcc_top dut (
        .aclk                  (aclk),
        .aresetn               (aresetn),
        .ce                    (ce),
        .axi_req               (axi_req),
        .axi_rsp               (axi_rsp),
        .subclock_mode         (subclock_mode),
        .subclock_tick         (tick_cnt[2:0] == 3'h0),
        .fast_oscillator_clock (tick_cnt[1:0] == 2'h0),
        .external_event_input  (external_event_input),
        .external_trigger      (external_trigger),
        .channel_pin           (channel_pin)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        tick_cnt <= tick_cnt + 8'h01;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // nonblocking drives after the rising edge keep two drives of one strobe out of one time step
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= {24'h0, addr};
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= data;
        axi_req.wstrb <= 4'hf;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1);
        axi_req.bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [31:0] data);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= {24'h0, addr};
        axi_req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        data = axi_rsp.rdata;
        rsp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // start, run, stop; the bus adds a few cycles to the window
    task automatic run(input logic [7:0] cc, input int cyc);
        wr(`TCC_OFS_COUNT_CONTROL, {24'h0, cc});
        wr(`TCC_OFS_TIMER_COUNT, 32'h0);
        wr(`TCC_OFS_MODE, 32'h88);
        repeat (cyc) @(posedge aclk);
        wr(`TCC_OFS_MODE, 32'h08);
        rd(`TCC_OFS_TIMER_COUNT, cnt);
    endtask : run

    task automatic t_reset();
        rd(`TCC_OFS_COUNT_CONTROL, cnt);
        check("count_control", cnt, 32'h00);
        rd(`TCC_OFS_TRIGGER_CONTROL, cnt);
        check("trigger_control", cnt, 32'h1f);
        rd(`TCC_OFS_MODE, cnt);
        check("mode", cnt, 32'h48);
        check("pins", {28'h0, channel_pin}, 32'h0);
        rd(8'h40, cnt);
        check("unmapped resp", {30'h0, rsp}, {30'h0, `TCC_RESP_SLVERR});
        wr(`TCC_OFS_TRIGGER_CONTROL, 32'h00);
        rd(`TCC_OFS_TRIGGER_CONTROL, cnt);
        check("reserved ones", cnt, 32'h1f);
        wr(`TCC_OFS_TRIGGER_CONTROL, 32'he0);
        rd(`TCC_OFS_TRIGGER_CONTROL, cnt);
        check("trigger fields", cnt, 32'hff);
        wr(`TCC_OFS_TRIGGER_CONTROL, 32'h00);
        $display("test reset and registers done");
    endtask : t_reset

    task automatic t_levels();
        wr(`TCC_OFS_COUNT_CONTROL, 32'h0f);
        check("pins all", {28'h0, channel_pin}, 32'hf);
        wr(`TCC_OFS_COUNT_CONTROL, 32'h0a);
        check("pins b d", {28'h0, channel_pin}, 32'ha);
        wr(`TCC_OFS_COUNT_CONTROL, 32'h00);
        $display("test initial levels done");
    endtask : t_levels

    task automatic t_sources();
        int div [7] = '{1, 2, 4, 8, 32, 4, 8};
        logic [7:0] cc [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40,
                              8'h60, 8'h00};
        for (int i = 0; i < 7; i++) begin
            subclock_mode <= (i == 6);
            run(cc[i], 320);
            check("rate", (cnt >= 320 / div[i] - 1) &&
                  (cnt <= 330 / div[i] + 1), 1);
        end
        subclock_mode <= 1'b0;
        wr(`TCC_OFS_COUNT_CONTROL, 32'h50);
        wr(`TCC_OFS_TIMER_COUNT, 32'h0);
        wr(`TCC_OFS_MODE, 32'h88);
        repeat (5) begin
            repeat (8) @(posedge aclk);
            external_event_input <= 1'b1;
            repeat (8) @(posedge aclk);
            external_event_input <= 1'b0;
        end
        repeat (10) @(posedge aclk);
        wr(`TCC_OFS_MODE, 32'h08);
        rd(`TCC_OFS_TIMER_COUNT, cnt);
        check("event count", cnt, 32'h5);
        $display("test count sources done");
    endtask : t_sources

    task automatic t_match_a();
        wr(`TCC_OFS_COMPARE_A, 32'h9);
        run(8'h80, 100);
        check("clear at a", cnt <= 9, 1);
        run(8'h00, 100);
        check("free run", cnt >= 100, 1);
        wr(`TCC_OFS_COMPARE_A, 32'd20);
        wr(`TCC_OFS_TRIGGER_CONTROL, 32'h20);
        wr(`TCC_OFS_TIMER_COUNT, 32'h0);
        wr(`TCC_OFS_MODE, 32'h80);
        repeat (100) @(posedge aclk);
        rd(`TCC_OFS_TIMER_COUNT, cnt);
        check("halt at a", cnt >= 20 && cnt <= 21, 1);
        rd(`TCC_OFS_MODE, cnt);
        check("start cleared", cnt[7], 0);
        wr(`TCC_OFS_MODE, 32'h08);
        wr(`TCC_OFS_TRIGGER_CONTROL, 32'h00);
        wr(`TCC_OFS_COMPARE_A, 32'hffff);
        $display("test match a done");
    endtask : t_match_a

    // enable low must freeze the count; only the bus cycles may count
    task automatic t_freeze();
        wr(`TCC_OFS_COUNT_CONTROL, 32'h00);
        wr(`TCC_OFS_TIMER_COUNT, 32'h0);
        wr(`TCC_OFS_MODE, 32'h88);
        ce <= 1'b0;
        repeat (100) @(posedge aclk);
        ce <= 1'b1;
        wr(`TCC_OFS_MODE, 32'h08);
        rd(`TCC_OFS_TIMER_COUNT, cnt);
        check("frozen count", cnt <= 8, 1);
        $display("test clock enable freeze done");
    endtask : t_freeze

    task automatic t_trig(input logic [1:0] code, input logic dual,
                          input logic rise, input logic exp_clear);
        external_trigger <= !rise;
        wr(`TCC_OFS_TRIGGER_CONTROL, {24'h0, code, 6'h00});
        wr(`TCC_OFS_TIMER_COUNT, 32'h0);
        wr(`TCC_OFS_MODE, dual ? 32'h88 : 32'h80);
        repeat (150) @(posedge aclk);
        external_trigger <= rise;
        repeat (10) @(posedge aclk);
        rd(`TCC_OFS_TIMER_COUNT, cnt);
        wr(`TCC_OFS_MODE, 32'h08);
        check("trigger clear", cnt < 100, exp_clear);
        $display("test trigger %b dual select %b edge %b done",
                 code, dual, rise);
    endtask : t_trig

    initial begin
        aresetn = 1'b0;
        ce = 1'b1;
        axi_req = '0;
        subclock_mode = 1'b0;
        external_event_input = 1'b0;
        external_trigger = 1'b0;
        tick_cnt = 8'h00;
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_levels();
        t_sources();
        t_match_a();
        t_freeze();
        t_trig(2'b00, 1'b0, 1'b1, 1'b0);
        t_trig(2'b01, 1'b0, 1'b1, 1'b1);
        t_trig(2'b01, 1'b0, 1'b0, 1'b0);
        t_trig(2'b10, 1'b0, 1'b0, 1'b1);
        t_trig(2'b10, 1'b0, 1'b1, 1'b0);
        t_trig(2'b11, 1'b0, 1'b1, 1'b1);
        t_trig(2'b11, 1'b0, 1'b0, 1'b1);
        t_trig(2'b11, 1'b1, 1'b1, 1'b0);
        give_verdict();
    end
endmodule : timer_count_control_tb
